// ==== hw/mfic_pkg.sv ====
// Package for the grouped multi-function interrupt control block.
// Assumes an APB master on mclk and group request pulses from peripherals.
//==========================================================================
package mfic_pkg;
   //=======================================================================
   // Register map (byte addresses)
   localparam logic [11:0] CTRL_OFS   = 12'h000; // group control register
   localparam logic [11:0] GLOBAL_OFS = 12'h004; // global enable, bit 0
   localparam logic [11:0] STAT_OFS   = 12'h008; // sticky event status
   localparam logic [11:0] MASK_OFS   = 12'h00C; // status mask
   //=======================================================================
   // Field positions and reset values
   localparam int          FLAG_LSB   = 4;
   localparam int          EN_LSB     = 0;
   localparam int          GLOBAL_BIT = 0;
   localparam logic [7:0]  CTRL_RST   = 8'h00;
   localparam logic [3:0]  GRP_RST    = 4'h0;
   localparam int          MAX_GROUPS = 4;
   //=======================================================================
   // APB request carrier
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } mfic_apb_req_t;
endpackage : mfic_pkg

// ==== hw/mfic_top.sv ====
// Grouped multi-function interrupt control register with APB access.
// Assumes group events are one-cycle pulses on mclk from on-chip logic.
`timescale 1ns/1ps
module mfic_top #(
   parameter int GROUPS = 4
) (
   input  wire logic                 mclk,
   input  wire logic                 rst_n,
   input  wire mfic_pkg::mfic_apb_req_t apbReq,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   input  wire logic [3:0]           groupEvent,
   output logic [3:0]                groupIrq,
   output logic                      irq
);
   //=======================================================================
   // Elaboration check
   initial begin
      if (GROUPS != 3 && GROUPS != mfic_pkg::MAX_GROUPS) begin
         $error("GROUPS must be 3 or 4");
      end
   end

   //=======================================================================
   // State
   logic [3:0] groupFlag_r;
   logic [3:0] groupFlag_nxt;
   logic [3:0] groupEn_r;
   logic [3:0] groupEn_nxt;
   logic       globalEn_r;
   logic [3:0] evtStat_r;
   logic [3:0] evtStat_nxt;
   logic [3:0] evtMask_r;
   logic [3:0] implMask;

   //=======================================================================
   // Decode
   wire logic accessPh = apbReq.psel & apbReq.penable;
   wire logic wrEn     = accessPh & apbReq.pwrite;
   wire logic selCtrl  = apbReq.paddr == mfic_pkg::CTRL_OFS;
   wire logic selGlob  = apbReq.paddr == mfic_pkg::GLOBAL_OFS;
   wire logic selStat  = apbReq.paddr == mfic_pkg::STAT_OFS;
   wire logic selMask  = apbReq.paddr == mfic_pkg::MASK_OFS;
   wire logic hitAny   = selCtrl | selGlob | selStat | selMask;
   wire logic [3:0] wrFlag = apbReq.pwdata[mfic_pkg::FLAG_LSB +: 4];
   wire logic [3:0] wrEnb  = apbReq.pwdata[mfic_pkg::EN_LSB +: 4];

   assign implMask = (GROUPS == mfic_pkg::MAX_GROUPS) ? 4'hF : 4'h7;

   //=======================================================================
   // Next values of flags and enables
   // Event sets flag
   assign groupFlag_nxt = ((wrEn && selCtrl) ? wrFlag : groupFlag_r)
                        | groupEvent;
   assign groupEn_nxt = (wrEn && selCtrl) ? wrEnb : groupEn_r;
   // Sticky status, write one clears, set wins
   assign evtStat_nxt = ((wrEn && selStat) ? (evtStat_r & ~wrFlag)
                        : evtStat_r) | (groupEvent & implMask);

   //=======================================================================
   // Register file
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         groupFlag_r <= mfic_pkg::GRP_RST;
         groupEn_r   <= mfic_pkg::GRP_RST;
         globalEn_r  <= 1'b0;
         evtStat_r   <= mfic_pkg::GRP_RST;
         evtMask_r   <= mfic_pkg::GRP_RST;
      end else begin
         groupFlag_r <= groupFlag_nxt & implMask;
         groupEn_r   <= groupEn_nxt & implMask;
         evtStat_r   <= evtStat_nxt;
         if (wrEn && selGlob) begin
            globalEn_r <= apbReq.pwdata[mfic_pkg::GLOBAL_BIT];
         end
         if (wrEn && selMask) begin
            evtMask_r <= wrFlag & implMask;
         end
      end
   end

   //=======================================================================
   // Read mux
   wire logic [7:0] ctrlRd = {groupFlag_r, groupEn_r};
   wire logic [31:0] rdMux =
        selCtrl ? {24'h000000, ctrlRd}
      : selGlob ? {31'h00000000, globalEn_r}
      : selStat ? {24'h000000, evtStat_r, 4'h0}
      : selMask ? {24'h000000, evtMask_r, 4'h0}
      : 32'h00000000;

   // Bus answer, zero wait states, error on unmapped address
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready  <= apbReq.psel & ~apbReq.penable;
         pslverr <= apbReq.psel & ~apbReq.penable & ~hitAny;
         prdata  <= (apbReq.psel & ~apbReq.penable & ~apbReq.pwrite)
                    ? rdMux : 32'h00000000;
      end
   end

   //=======================================================================
   // Interrupt outputs
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         groupIrq <= 4'h0;
         irq      <= 1'b0;
      end else begin
         groupIrq <= groupFlag_r & groupEn_r & {4{globalEn_r}};
         irq      <= |(evtStat_r & evtMask_r);
      end
   end
endmodule : mfic_top

// ==== dv/mfic_sva.sv ====
// Checker for the group interrupt block.
// Assumes a bind onto mfic_top.
`timescale 1ns/1ps
module mfic_sva #(parameter int GROUPS = 4) (
   input wire logic                    mclk,
   input wire logic                    rst_n,
   input wire mfic_pkg::mfic_apb_req_t apbReq,
   input wire logic                    pready,
   input wire logic [31:0]             prdata,
   input wire logic                    pslverr,
   input wire logic [3:0]              groupEvent,
   input wire logic [3:0]              groupIrq,
   input wire logic                    irq
);
   //=======================================================
   // Bus answer and service request checks
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_setup; apbReq.psel && !apbReq.penable; endsequence
   sequence s_acc; apbReq.psel && apbReq.penable && pready; endsequence
   property p_rdy; s_setup |=> s_acc; endproperty
   a_rdy: assert property (p_rdy) else $error("no answer");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("long ready");
   property p_err; pready && apbReq.paddr[11:4] != 0 |-> pslverr; endproperty
   a_err: assert property (p_err) else $error("no slave error");
   property p_erq; pslverr |-> pready; endproperty
   a_erq: assert property (p_erq) else $error("stray error");
   property p_zero; !pready |-> prdata == 0; endproperty
   a_zero: assert property (p_zero) else $error("stray data");
   property p_hi; pready |-> prdata[31:8] == 0; endproperty
   a_hi: assert property (p_hi) else $error("upper bits");
   property p_fall;
      $fell(groupIrq[0]) |-> $past(apbReq.penable, 2);
   endproperty
   a_fall: assert property (p_fall) else $error("irq drop");
   property p_small; GROUPS == 3 |-> !groupIrq[3]; endproperty
   a_small: assert property (p_small) else $error("group 3");
endmodule : mfic_sva

// ==== dv/tb_top.sv ====
// Bench for the group interrupt block, APB scenarios.
// Assumes mfic_pkg and mfic_top compiled first.
`timescale 1ns/1ps
module tb_top;
   logic mclk = 0, rst_n = 0, pready, pslverr, irq, err;
   mfic_pkg::mfic_apb_req_t req = '0;
   logic [31:0] prdata, rd;
   logic [3:0] ev = 4'h0, gIrq;
   int n_mismatch = 0, n_checks = 0;
   always #12.5 mclk = ~mclk;
   mfic_top uut (.mclk(mclk), .rst_n(rst_n), .apbReq(req),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .groupEvent(ev), .groupIrq(gIrq), .irq(irq));
   //=======================================================
   // Shared tasks
   task chk(input logic [31:0] s, e);
      n_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: %h not %h", $time, s, e);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk) req <= '{1'b1, 1'b0, w, a, d};
      @(posedge mclk) req.penable <= 1'b1;
      do @(posedge mclk) n++; while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      req <= '0;
   endtask : apb
   task rdc(input logic [11:0] a, input logic [31:0] e);
      apb(0, a, 0);
      chk(rd, e);
   endtask : rdc
   task tick(input logic [3:0] e);
      @(posedge mclk) ev <= e;
      @(posedge mclk) ev <= 4'h0;
      repeat (2) @(posedge mclk);
   endtask : tick
   task complete_run;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run
   //=======================================================
   // Scenarios
   task t_regs;
      rdc(12'h000, 32'h0);
      apb(1, 12'h000, 32'h88);
      rdc(12'h000, 32'h88);
      apb(1, 12'h000, 32'h77);
      rdc(12'h000, 32'h77);
      apb(0, 12'h010, 0);
      chk(err, 1'b1);
      $display("regs done");
   endtask : t_regs
   task t_svc;
      apb(1, 12'h000, 32'h0);
      tick(4'hF);
      rdc(12'h000, 32'hF0);
      apb(1, 12'h000, 32'hFF);
      tick(4'h0);
      chk(gIrq, 4'h0);
      apb(1, 12'h004, 32'h1);
      tick(4'h0);
      chk(gIrq, 4'hF);
      apb(1, 12'h000, 32'h0F);
      tick(4'h0);
      chk(gIrq, 4'h0);
      $display("svc done");
   endtask : t_svc
   task t_int;
      apb(1, 12'h00C, 32'h0);
      tick(4'h2);
      chk(irq, 1'b0);
      apb(1, 12'h00C, 32'hF0);
      tick(4'h0);
      chk(irq, 1'b1);
      apb(1, 12'h008, 32'hF0);
      tick(4'h0);
      chk(irq, 1'b0);
      rdc(12'h008, 32'h0);
      rdc(12'h00C, 32'hF0);
      chk(err, 1'b0);
      $display("int done");
   endtask : t_int
   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      t_regs();
      t_svc();
      t_int();
      complete_run();
   end
   initial begin
      #50us;
      n_mismatch++;
      complete_run();
   end
endmodule : tb_top
bind mfic_top mfic_sva #(.GROUPS(GROUPS)) sva (.mclk(mclk),
   .rst_n(rst_n), .apbReq(apbReq), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .groupEvent(groupEvent), .groupIrq(groupIrq),
   .irq(irq));
